// ### hw/ista_top.sv
//==================================================================
// Purpose: Speed, role enable and remote address configuration
// Assumes: Avalon-MM slave on CORE_CLK_IN, sync active-high reset
// Notes:   Bus pins are sampled, never driven here
//==================================================================
// How it works
// (R1) Speed field codes standard 1, fast 2, high 3; resets to 2.
// (R2) Written speed below 1 or above maximum stores the maximum.
// (R3) Speed also picks the target-side spike filter setting.
// (R4) Ultra-fast option makes the speed field meaningless.
// (R5) Controller enable bit allows controller operation; resets to one.
// (R6) Software sets responder-off whenever it sets controller enable.
// (R7) Remote address writes land only while block enable is clear.
// (R8) Software may rewrite address with FIFO busy if commands ignore it.
// (R9) Pure target use needs no remote address write.
// (R10) Special bit clear ignores bit 10; set issues call or start byte.
// (R11) Bit 10 chooses general call (0) or start byte (1).
// (R12) Read command queued during general call raises transmit abort.
// (R13) General call persists until software clears the special bit; the code also ends it when a write sets bit 10.
// (R14) Ten-bit address drives every transaction except a general call.
// (R15) Software writes the address once to generate a start byte.
// (R16) Own address as target gives one-way loopback only.
// (R17) Controller never counts itself as a recipient.
// (R18) Remote address register holds 12 bits; 31:12 reserved.
// (R19) Config bit 6 disables target role; resets to one.
// (R20) Reserved remote address bits read zero, writes ignored.
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps
module ista_top
	import ista_pkg::*;
#(
	parameter logic [1:0] HIGHEST_RATE_OPTION = SPEED_HIGH
) (
	input  wire logic                 CORE_CLK_IN,
	input  wire logic                 RST_IN,
	input  wire logic [ADDR_W-1:0]    AVS_ADDRESS_IN,
	input  wire logic                 AVS_READ_IN,
	input  wire logic                 AVS_WRITE_IN,
	input  wire logic [31:0]          AVS_WRITEDATA_IN,
	input  wire logic [3:0]           AVS_BYTEENABLE_IN,
	output logic      [31:0]          AVS_READDATA_OUT,
	output logic                      AVS_WAITREQUEST_OUT,
	input  wire logic                 BLOCK_ENABLE_IN,
	input  wire logic                 TX_FIFO_EMPTY_IN,
	input  wire logic                 ULTRAFAST_OPTION_IN,
	input  wire logic [RA_ADDR_W-1:0] OWN_RESPONDER_ADDRESS_IN,
	input  wire logic                 CMD_PUSH_IN,
	input  wire logic                 CMD_READ_IN,
	input  wire logic                 SCL_IN,
	input  wire logic                 SDA_IN,
	output logic      [1:0]           SPEED_OUT,
	output logic                      SPEED_VALID_OUT,
	output logic                      SPIKE_HS_SEL_OUT,
	output logic                      CTRL_EN_OUT,
	output logic                      RESP_EN_OUT,
	output logic      [RA_ADDR_W-1:0] TARGET_ADDR_OUT,
	output logic                      ADDR_USED_OUT,
	output logic                      GEN_CALL_OUT,
	output logic                      START_BYTE_OUT,
	output logic                      TX_ABORT_OUT,
	output logic                      LOOPBACK_SIMPLEX_OUT,
	output logic                      SELF_ADDR_OUT,
	output logic                      BUS_BUSY_OUT
);
	//==============================================================
	// Elaboration check
	generate
		if (HIGHEST_RATE_OPTION < SPEED_STD) begin : g_bad_rate
			$error("HIGHEST_RATE_OPTION must be 1 to 3");
		end
	endgenerate

	//==============================================================
	// Bus slave handshake
	ista_bus_e   bus_state_r;
	ista_bus_e   bus_state_nxt;
	logic        waitreq_r;
	logic [31:0] rdata_r;

	wire         req       = AVS_READ_IN | AVS_WRITE_IN;
	wire         in_idle   = (bus_state_r == ISTA_BUS_IDLE);
	wire         in_ack    = (bus_state_r == ISTA_BUS_ACK);
	// Write lands on the edge the master sees waitrequest low
	wire         wr_fire   = AVS_WRITE_IN & in_ack;
	wire         hit_cfg   = (AVS_ADDRESS_IN == OFS_CONFIG);
	wire         hit_ra    = (AVS_ADDRESS_IN == OFS_REMOTE_ADDR);
	wire         hit_stat  = (AVS_ADDRESS_IN == OFS_STATUS);

	always_comb begin
		case (bus_state_r)
			ISTA_BUS_IDLE: bus_state_nxt = req ? ISTA_BUS_ACK : ISTA_BUS_IDLE;
			ISTA_BUS_ACK:  bus_state_nxt = ISTA_BUS_IDLE;
			default:       bus_state_nxt = ISTA_BUS_IDLE;
		endcase
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (RST_IN) begin
			bus_state_r <= ISTA_BUS_IDLE;
			waitreq_r   <= 1'h1;
		end else begin
			bus_state_r <= bus_state_nxt;
			waitreq_r   <= (bus_state_nxt != ISTA_BUS_ACK);
		end
	end

	//==============================================================
	// Config register
	logic       ctrl_en_r;
	logic       ctrl_en_nxt;
	logic [1:0] speed_r;
	logic [1:0] speed_nxt;
	logic       resp_off_r;
	logic       resp_off_nxt;
	logic       resp_en_r;
	logic [1:0] speed_legal;

	wire        cfg_wr = wr_fire & hit_cfg & AVS_BYTEENABLE_IN[0];

	ista_speed_clamp #(
		.MAX_CODE (HIGHEST_RATE_OPTION)
	) u_clamp (
		.raw_in    (AVS_WRITEDATA_IN[CFG_SPEED_MSB:CFG_SPEED_LSB]),
		.legal_out (speed_legal)
	);

	// Responder-off pairing with controller enable is left to software
	assign ctrl_en_nxt  = cfg_wr ? AVS_WRITEDATA_IN[CFG_CTRL_EN_BIT] : ctrl_en_r;   // [R5]
	assign speed_nxt    = cfg_wr ? speed_legal : speed_r;                           // [R2]
	assign resp_off_nxt = cfg_wr ? AVS_WRITEDATA_IN[CFG_RESP_OFF_BIT] : resp_off_r; // [R19]

	always_ff @(posedge CORE_CLK_IN) begin
		if (RST_IN) begin
			ctrl_en_r  <= CFG_CTRL_EN_RST;  // [R5]
			speed_r    <= CFG_SPEED_RST;    // [R1]
			resp_off_r <= CFG_RESP_OFF_RST; // [R19]
			resp_en_r  <= ~CFG_RESP_OFF_RST;
		end else begin
			ctrl_en_r  <= ctrl_en_nxt;
			speed_r    <= speed_nxt;
			resp_off_r <= resp_off_nxt;
			// Own flop so the output needs no inverter after the register
			resp_en_r  <= ~resp_off_nxt;    // [R19]
		end
	end

	//==============================================================
	// Remote address register
	logic [RA_W-1:0] ra_r;
	logic [RA_W-1:0] ra_nxt;

	// Tx FIFO state deliberately not checked; software owns that hazard
	wire ra_wr    = wr_fire & hit_ra & ~BLOCK_ENABLE_IN;  // [R7] [R8]
	wire ra_wr_lo = ra_wr & AVS_BYTEENABLE_IN[0];
	wire ra_wr_hi = ra_wr & AVS_BYTEENABLE_IN[1];

	// Only 12 bits exist; upper write data is dropped
	assign ra_nxt[7:0]      = ra_wr_lo ? AVS_WRITEDATA_IN[7:0]      : ra_r[7:0];      // [R18] [R20]
	assign ra_nxt[RA_W-1:8] = ra_wr_hi ? AVS_WRITEDATA_IN[RA_W-1:8] : ra_r[RA_W-1:8]; // [R18]

	always_ff @(posedge CORE_CLK_IN) begin
		if (RST_IN) begin
			ra_r <= RA_RST;  // [R14] [R11]
		end else begin
			ra_r <= ra_nxt;
		end
	end

	//==============================================================
	// Address decode of the stored word
	wire                 special_nxt = ra_nxt[RA_SPECIAL_BIT];
	wire                 bcast_nxt   = ra_nxt[RA_BCAST_BIT];
	wire [RA_ADDR_W-1:0] addr_nxt    = ra_nxt[RA_ADDR_W-1:0];
	// Identity query bit is not implemented, so it always reads clear
	wire                 gcall_nxt   = special_nxt & ~bcast_nxt;  // [R10] [R11] [R13]
	wire                 sbyte_nxt   = special_nxt & bcast_nxt;   // [R10] [R11] [R15]
	wire                 addr_use    = ~gcall_nxt;                // [R14]
	wire                 self_hit    = ~special_nxt & (addr_nxt == OWN_RESPONDER_ADDRESS_IN);
	// Loopback needs the responder side awake to receive
	wire                 loop_ok     = self_hit & ~resp_off_nxt & ctrl_en_nxt;  // [R16]

	//==============================================================
	// Speed and filter selection
	logic       ultra_r;
	logic       spd_valid_r;
	logic       spike_hs_r;
	logic [1:0] speed_out_r;

	// Ultra-fast mode hides the field rather than altering the store
	wire [1:0]  speed_eff = ULTRAFAST_OPTION_IN ? 2'h0 : speed_nxt;              // [R4]
	wire        hs_sel    = ~ULTRAFAST_OPTION_IN & (speed_nxt == SPEED_HIGH);  // [R3]

	always_ff @(posedge CORE_CLK_IN) begin
		if (RST_IN) begin
			ultra_r     <= 1'h0;
			spd_valid_r <= 1'h1;
			spike_hs_r  <= 1'h0;
			speed_out_r <= CFG_SPEED_RST;
		end else begin
			ultra_r     <= ULTRAFAST_OPTION_IN;
			spd_valid_r <= ~ULTRAFAST_OPTION_IN;  // [R4]
			spike_hs_r  <= hs_sel;
			speed_out_r <= speed_eff;
		end
	end

	//==============================================================
	// Derived role and address outputs
	logic gcall_r;
	logic sbyte_r;
	logic addr_use_r;
	logic loop_r;
	logic self_r;
	logic abort_r;

	// Reads are not legal towards a general call address
	wire  abort_set = CMD_PUSH_IN & CMD_READ_IN & gcall_r & ctrl_en_r;  // [R12]

	always_ff @(posedge CORE_CLK_IN) begin
		if (RST_IN) begin
			gcall_r    <= 1'h0;
			sbyte_r    <= 1'h0;
			addr_use_r <= 1'h1;
			loop_r     <= 1'h0;
			self_r     <= 1'h0;
			abort_r    <= 1'h0;
		end else begin
			gcall_r    <= gcall_nxt;
			sbyte_r    <= sbyte_nxt;
			addr_use_r <= addr_use;
			loop_r     <= loop_ok;
			self_r     <= self_hit;  // [R17]
			abort_r    <= abort_set;
		end
	end

	//==============================================================
	// Bus line watch for START and STOP
	logic [1:0] line_s;
	logic       scl_p_r;
	logic       sda_p_r;
	logic       busy_r;

	ista_sync #(
		.WIDTH   (2),
		.RST_VAL (2'h3)
	) u_sync (
		.clk_in   (CORE_CLK_IN),
		.rst_in   (RST_IN),
		.async_in ({SCL_IN, SDA_IN}),
		.sync_out (line_s)
	);

	wire scl_s   = line_s[1];
	wire sda_s   = line_s[0];
	wire scl_hi  = scl_s & scl_p_r;
	wire st_cond = scl_hi & sda_p_r & ~sda_s;
	wire sp_cond = scl_hi & ~sda_p_r & sda_s;

	always_ff @(posedge CORE_CLK_IN) begin
		if (RST_IN) begin
			scl_p_r <= 1'h1;
			sda_p_r <= 1'h1;
			busy_r  <= 1'h0;
		end else begin
			scl_p_r <= scl_s;
			sda_p_r <= sda_s;
			// A fresh START outranks a STOP seen in the same cycle
			busy_r  <= st_cond | (busy_r & ~sp_cond);
		end
	end

	//==============================================================
	// Read data
	wire [31:0] rd_cfg  = {25'h0, resp_off_r, 3'h0, speed_r, ctrl_en_r};
	wire [31:0] rd_ra   = {20'h0, ra_r};  // [R20]
	wire [31:0] rd_stat = {26'h0, self_r, loop_r, gcall_r, TX_FIFO_EMPTY_IN, BLOCK_ENABLE_IN, busy_r};
	// Unmapped offsets read zero
	wire [31:0] rd_mux  = hit_cfg  ? rd_cfg  :
	                      hit_ra   ? rd_ra   :
	                      hit_stat ? rd_stat : 32'h0;

	always_ff @(posedge CORE_CLK_IN) begin
		if (RST_IN) begin
			rdata_r <= 32'h0;
		end else if (in_idle & req) begin
			rdata_r <= AVS_READ_IN ? rd_mux : 32'h0;
		end
	end

	//==============================================================
	// Output wiring, all from flops
	assign AVS_READDATA_OUT     = rdata_r;
	assign AVS_WAITREQUEST_OUT  = waitreq_r;
	assign SPEED_OUT            = speed_out_r;
	assign SPEED_VALID_OUT      = spd_valid_r;
	assign SPIKE_HS_SEL_OUT     = spike_hs_r;
	assign CTRL_EN_OUT          = ctrl_en_r;
	assign RESP_EN_OUT          = resp_en_r;
	assign TARGET_ADDR_OUT      = ra_r[RA_ADDR_W-1:0];
	assign ADDR_USED_OUT        = addr_use_r;
	assign GEN_CALL_OUT         = gcall_r;
	assign START_BYTE_OUT       = sbyte_r;
	assign TX_ABORT_OUT         = abort_r;
	assign LOOPBACK_SIMPLEX_OUT = loop_r;
	assign SELF_ADDR_OUT        = self_r;
	assign BUS_BUSY_OUT         = busy_r;

	//==============================================================
	// Checks
	default clocking cb @(posedge CORE_CLK_IN); endclocking
	default disable iff (RST_IN);

	sequence s_ack_pulse;
		!AVS_WAITREQUEST_OUT ##1 AVS_WAITREQUEST_OUT;
	endsequence

	sequence s_cfg_bad_write;
		cfg_wr && ((AVS_WRITEDATA_IN[2:1] == 2'h0) || (AVS_WRITEDATA_IN[2:1] > HIGHEST_RATE_OPTION));
	endsequence

	a_speed_reset_val: assert property ($past(RST_IN) |-> speed_r == 2'h2)  // [R1]
		else $error("speed not 2 after reset");
	a_speed_clamp_max: assert property (s_cfg_bad_write |=> speed_r == HIGHEST_RATE_OPTION)  // [R2]
		else $error("illegal speed not clamped");
	a_spike_follows_speed: assert property (SPIKE_HS_SEL_OUT == ((speed_r == 2'h3) && !ultra_r))  // [R3]
		else $error("spike select mismatch");
	a_ultra_hides_speed: assert property (ultra_r |-> !SPEED_VALID_OUT && SPEED_OUT == 2'h0)  // [R4]
		else $error("speed shown in ultra-fast mode");
	a_ctrl_en_write: assert property (cfg_wr |=> CTRL_EN_OUT == $past(AVS_WRITEDATA_IN[0]))  // [R5]
		else $error("controller enable not stored");
	a_resp_off_write: assert property (cfg_wr |=> RESP_EN_OUT == !$past(AVS_WRITEDATA_IN[6]))  // [R19]
		else $error("responder enable not stored");
	a_addr_locked: assert property (wr_fire && hit_ra && BLOCK_ENABLE_IN |=> $stable(ra_r))  // [R7]
		else $error("address written while enabled");
	a_read_abort_gc: assert property (CMD_PUSH_IN && CMD_READ_IN && GEN_CALL_OUT && CTRL_EN_OUT
		|=> TX_ABORT_OUT)  // [R12]
		else $error("read during general call not aborted");
	a_gcall_sticky: assert property (GEN_CALL_OUT && !ra_wr_hi |=> GEN_CALL_OUT)  // [R13]
		else $error("general call dropped");
	a_gcall_no_loop: assert property (GEN_CALL_OUT |-> !LOOPBACK_SIMPLEX_OUT && !ADDR_USED_OUT)  // [R14]
		else $error("address used during general call");
	a_ra_reserved_zero: assert property (in_ack && hit_ra && AVS_READ_IN
		|-> AVS_READDATA_OUT[31:12] == 20'h0)  // [R18]
		else $error("reserved bits not zero");
	a_bus_one_ack: assert property (in_idle && req |=> s_ack_pulse)
		else $error("bus answer not one cycle");
endmodule : ista_top

// ### hw/ista_pkg.sv
//==================================================================
// Purpose: Shared constants for the speed and target address slice
// Assumes: 32-bit Avalon-MM register word, byte addressing
// Notes:   Offsets are byte addresses
//==================================================================
package ista_pkg;
	//==============================================================
	// Register map
	localparam int          ADDR_W          = 4;
	localparam logic [3:0]  OFS_CONFIG      = 4'h0;
	localparam logic [3:0]  OFS_REMOTE_ADDR = 4'h4;
	localparam logic [3:0]  OFS_STATUS      = 4'h8;
	//==============================================================
	// Config word fields
	localparam int          CFG_CTRL_EN_BIT  = 0;
	localparam int          CFG_SPEED_LSB    = 1;
	localparam int          CFG_SPEED_MSB    = 2;
	localparam int          CFG_RESP_OFF_BIT = 6;
	localparam logic        CFG_CTRL_EN_RST  = 1'h1;
	localparam logic [1:0]  CFG_SPEED_RST    = 2'h2;
	localparam logic        CFG_RESP_OFF_RST = 1'h1;
	//==============================================================
	// Speed codes
	localparam logic [1:0]  SPEED_STD  = 2'h1;
	localparam logic [1:0]  SPEED_FAST = 2'h2;
	localparam logic [1:0]  SPEED_HIGH = 2'h3;
	//==============================================================
	// Remote address word fields
	localparam int          RA_W          = 12;
	localparam int          RA_ADDR_W     = 10;
	localparam int          RA_BCAST_BIT  = 10;
	localparam int          RA_SPECIAL_BIT = 11;
	localparam logic [11:0] RA_RST        = 12'h055;
	//==============================================================
	// Status word fields
	localparam int          ST_BUS_BUSY_BIT = 0;
	localparam int          ST_LOCKED_BIT   = 1;
	localparam int          ST_TX_EMPTY_BIT = 2;
	localparam int          ST_GCALL_BIT    = 3;
	localparam int          ST_LOOP_BIT     = 4;
	localparam int          ST_SELF_BIT     = 5;
	//==============================================================
	// Bus slave states
	typedef enum logic [1:0] {
		ISTA_BUS_IDLE = 2'b01,
		ISTA_BUS_ACK  = 2'b10
	} ista_bus_e;
endpackage : ista_pkg

// ### hw/ista_sync.sv
//==================================================================
// Purpose: Two-flop synchroniser, one lane per bit
// Assumes: Inputs asynchronous to clk_in
// Notes:   First stage feeds only the second stage
//==================================================================
`timescale 1ns/1ps
module ista_sync #(
	parameter int               WIDTH   = 2,
	parameter logic [WIDTH-1:0] RST_VAL = '1
) (
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_lane
			logic meta_r;
			logic hold_r;
			always_ff @(posedge clk_in) begin
				if (rst_in) begin
					meta_r <= RST_VAL[g];
					hold_r <= RST_VAL[g];
				end else begin
					meta_r <= async_in[g];
					hold_r <= meta_r;
				end
			end
			assign sync_out[g] = hold_r;
		end
	endgenerate
endmodule : ista_sync

// ### hw/ista_speed_clamp.sv
//==================================================================
// Purpose: Maps a written speed code onto a legal one
// Assumes: MAX_CODE already checked by the parent
// Notes:   Purely combinational
//==================================================================
`timescale 1ns/1ps
module ista_speed_clamp
	import ista_pkg::*;
#(
	parameter logic [1:0] MAX_CODE = SPEED_HIGH
) (
	input  wire logic [1:0] raw_in,
	output logic      [1:0] legal_out
);
	//==============================================================
	// Clamp
	wire too_low  = (raw_in < SPEED_STD);
	wire too_high = (raw_in > MAX_CODE);
	assign legal_out = (too_low || too_high) ? MAX_CODE : raw_in;  // [R2]
endmodule : ista_speed_clamp

// ### tb/ista_i2c_peer.sv
//==================================================================
// Purpose: Behavioural far-side bus party making START and STOP
// Assumes: Open-drain lines with pull-ups, so released means high
// Notes:   Link clock runs only inside a frame, 64 ns period
//==================================================================
`timescale 1ns/1ps
module ista_i2c_peer (
	output logic scl_out,
	output logic sda_out
);
	//==============================================================
	// Idle bus: both lines pulled high
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	//==============================================================
	// Frame pieces; split so the bench can look inside a frame
	task automatic start_frame(input int nbits);
		sda_out = 1'b0;
		#32;
		for (int i = 0; i < nbits; i++) begin
			scl_out = 1'b0;
			sda_out = i[0];
			#32;
			scl_out = 1'b1;
			#32;
		end
	endtask : start_frame
	task automatic stop_frame();
		scl_out = 1'b0;
		sda_out = 1'b0;
		#32;
		scl_out = 1'b1;
		#32;
		sda_out = 1'b1;
	endtask : stop_frame
endmodule : ista_i2c_peer

// ### tb/tb.sv
//==================================================================
// Purpose: Self-checking bench for the speed and remote address slice
// Assumes: Any number of wait cycles per register access
// Notes:   Config writes keep responder-off set with controller on
//==================================================================
`timescale 1ns/1ps
module tb;
	import ista_pkg::*;
	logic        clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, en = 1'b0;
	logic        txe = 1'b1, uf = 1'b0, push = 1'b0, cmdrd = 1'b0;
	logic [3:0]  adr = 4'h0;
	logic [31:0] wd = 32'h0, q;
	logic [9:0]  own = 10'h123;
	logic [31:0] rdata;
	logic [1:0]  spd;
	logic [9:0]  ta;
	logic        wreq, spv, spk, cen, ren, au, gc, sb, ab, lp, sf, bb, scl, sda;
	int          num_errors = 0;
	int          checks = 0;
	always #2.5 clk = ~clk;
	ista_i2c_peer peer (.scl_out(scl), .sda_out(sda));
	ista_top DUT (
		.CORE_CLK_IN(clk), .RST_IN(rst), .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr),
		.AVS_WRITEDATA_IN(wd), .AVS_BYTEENABLE_IN(4'hf), .AVS_READDATA_OUT(rdata),
		.AVS_WAITREQUEST_OUT(wreq), .BLOCK_ENABLE_IN(en), .TX_FIFO_EMPTY_IN(txe),
		.ULTRAFAST_OPTION_IN(uf), .OWN_RESPONDER_ADDRESS_IN(own), .CMD_PUSH_IN(push),
		.CMD_READ_IN(cmdrd), .SCL_IN(scl), .SDA_IN(sda), .SPEED_OUT(spd), .SPEED_VALID_OUT(spv),
		.SPIKE_HS_SEL_OUT(spk), .CTRL_EN_OUT(cen), .RESP_EN_OUT(ren), .TARGET_ADDR_OUT(ta),
		.ADDR_USED_OUT(au), .GEN_CALL_OUT(gc), .START_BYTE_OUT(sb), .TX_ABORT_OUT(ab),
		.LOOPBACK_SIMPLEX_OUT(lp), .SELF_ADDR_OUT(sf), .BUS_BUSY_OUT(bb)
	);
	//==============================================================
	// Shared tasks
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// No cycle count assumed; only the watchdog ends a stuck wait
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		adr <= a;
		wd  <= d;
		wr  <= w;
		rd  <= !w;
		do @(posedge clk); while (wreq !== 1'b0);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
		@(negedge clk);
	endtask : bus
	task automatic cmd(input logic r);
		@(posedge clk);
		push  <= 1'b1;
		cmdrd <= r;
		@(posedge clk);
		push <= 1'b0;
		@(negedge clk);
		chk("abort", 32'(ab), 32'(r));
		@(negedge clk);
		chk("abort end", 32'(ab), 32'h0);
	endtask : cmd
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : conclude
	//==============================================================
	// Scenarios
	task automatic t_reset();
		bus(1'b0, OFS_CONFIG, 32'h0);
		chk("config", q, 32'h45);
		chk("speed", 32'(spd), 32'h2);
		chk("ctrl en", 32'(cen), 32'h1);
		chk("resp en", 32'(ren), 32'h0);
		bus(1'b0, OFS_REMOTE_ADDR, 32'h0);
		chk("remote", q, 32'h55);
		chk("target", 32'(ta), 32'h55);
		$display("test reset done");
	endtask : t_reset
	task automatic t_speed();
		logic [1:0] e;
		for (int s = 0; s < 4; s++) begin
			e = (s == 0) ? 2'h3 : 2'(s);
			bus(1'b1, OFS_CONFIG, 32'h41 | 32'(s << 1));
			chk("speed", 32'(spd), 32'(e));
			chk("spike", 32'(spk), 32'(e == 2'h3));
			bus(1'b0, OFS_CONFIG, 32'h0);
			chk("config", q, 32'h41 | 32'(e << 1));
		end
		@(posedge clk) uf <= 1'b1;
		repeat (3) @(negedge clk);
		chk("ultra speed", 32'(spd), 32'h0);
		chk("ultra valid", 32'(spv), 32'h0);
		chk("ultra spike", 32'(spk), 32'h0);
		@(posedge clk) uf <= 1'b0;
		repeat (3) @(negedge clk);
		chk("speed back", 32'(spd), 32'h3);
		$display("test speed done");
	endtask : t_speed
	task automatic t_addr();
		@(posedge clk) en <= 1'b1;
		bus(1'b1, OFS_REMOTE_ADDR, 32'h123);
		bus(1'b0, OFS_REMOTE_ADDR, 32'h0);
		chk("locked", q, 32'h55);
		// FIFO holds entries; pending commands assumed address-free
		@(posedge clk) en <= 1'b0;
		txe <= 1'b0;
		bus(1'b1, OFS_REMOTE_ADDR, 32'hfffff3a5);
		bus(1'b0, OFS_REMOTE_ADDR, 32'h0);
		chk("remote", q, 32'h3a5);
		chk("target", 32'(ta), 32'h3a5);
		bus(1'b0, 4'hc, 32'h0);
		chk("unmapped", q, 32'h0);
		$display("test address done");
	endtask : t_addr
	task automatic t_special();
		bus(1'b1, OFS_REMOTE_ADDR, 32'h405);
		chk("plain gc", 32'({gc, sb, au}), 32'h1);
		bus(1'b1, OFS_REMOTE_ADDR, 32'h855);
		chk("gc", 32'({gc, sb, au}), 32'h4);
		bus(1'b0, OFS_STATUS, 32'h0);
		chk("status gc", q, 32'h8);
		cmd(1'b1);
		cmd(1'b0);
		cmd(1'b1);
		chk("gc held", 32'(gc), 32'h1);
		bus(1'b1, OFS_REMOTE_ADDR, 32'hc55);
		chk("start byte", 32'({gc, sb}), 32'h1);
		bus(1'b1, OFS_REMOTE_ADDR, 32'h055);
		cmd(1'b0);
		chk("gc clear", 32'(gc), 32'h0);
		$display("test special done");
	endtask : t_special
	task automatic t_self();
		bus(1'b1, OFS_REMOTE_ADDR, 32'(own));
		repeat (2) @(negedge clk);
		chk("self", 32'(sf), 32'h1);
		chk("loop off", 32'(lp), 32'h0);
		bus(1'b1, OFS_CONFIG, 32'h04);
		repeat (2) @(negedge clk);
		chk("ctrl off", 32'({cen, ren}), 32'h1);
		chk("loop ctrl off", 32'(lp), 32'h0);
		bus(1'b1, OFS_CONFIG, 32'h45);
		$display("test self done");
	endtask : t_self
	task automatic t_busy();
		peer.start_frame(4);
		@(negedge clk);
		chk("busy", 32'(bb), 32'h1);
		bus(1'b0, OFS_STATUS, 32'h0);
		chk("status busy", q, 32'h21);
		peer.stop_frame();
		repeat (6) @(negedge clk);
		chk("idle", 32'(bb), 32'h0);
		$display("test busy done");
	endtask : t_busy
	//==============================================================
	// Main sequence and watchdog
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_speed();
		t_addr();
		t_special();
		t_self();
		t_busy();
		conclude();
	end
	initial begin
		#20000;
		num_errors++;
		conclude();
	end
endmodule : tb
